// ---- backlight_supervisor.v ----
// backlight supervisor: boost setpoint, fault capture, thermal derating
`timescale 1ns/100ps
`include "bl_regs.vh"
// ---------------------------------------------------------------
// Notes on behaviour
// - adaptive mode steps the boost setpoint by 125 mV from headroom
// - adaptive start takes the manual code as first setpoint
// - manual code gives 10 V plus 1 V per step, 40 V at 30/31
// - over-voltage limit tracks the present setpoint
// - weakest-headroom string steers the boost to keep its margin
// - three-bit margin select sets target headroom 300 to 1200 mV
// - any fault pulls the fault pin low and is recorded
// - reading the fault register clears the record
// - enable low clears every recorded fault
// - a faulty string leaves the adaptive loop
// - fault bits show open or short and the faulty string count
// - one bit picks 3.3 V or 5.3 V string mismatch threshold
// - string faults detected only in mixed dimming mode
// - two-bit select: off, 2.7 V, 5.4 V, 8.1 V supply threshold
// - supply low stops boost and LEDs, faults, restarts on recovery
// - over-current shuts down, record held until read or enable low
// - over the limit duty drops 2% per degree while enabled
// - 11-bit temperature over high and low byte, high read first
// - two-bit limit select: off, 110, 120, 130 degrees
// - thermal derating raises no fault
// - 150 degrees shuts down and faults, resume below 130
// - auto-boost bit starts boost whenever backlight enabled
// ---------------------------------------------------------------
module backlight_supervisor #(
	parameter STEP_CYCLES = `STEP_CYCLES
) (
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire [7:0]  ADDR,
	input  wire [7:0]  WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [7:0]  RDATA,
	input  wire        EN_PIN,
	input  wire        MIXED_DIM,
	input  wire [3:0]  HEAD_LOW,
	input  wire [3:0]  HEAD_HIGH,
	input  wire [3:0]  STR_OPEN,
	input  wire [3:0]  STR_SHORT,
	input  wire        SUPPLY_LOW,
	input  wire        OVER_CURRENT,
	input  wire [10:0] TEMP_CODE,
	output reg         BOOST_ON,
	output reg         LED_ON,
	output wire [7:0]  BOOST_SET,
	output reg  [8:0]  OVP_SET,
	output reg  [2:0]  MARGIN_SEL,
	output reg         MISMATCH_SEL,
	output reg  [1:0]  SUPPLY_LOW_SEL,
	output reg  [3:0]  LOOP_MASK,
	output reg  [6:0]  DUTY_PCT,
	output reg         FAULT_O,
	output reg         FAULT_OE
);

// ---------------------------------------------------------------
// functions
// ---------------------------------------------------------------
	function [2:0] popcount4;
		input [3:0] v;
		begin
			popcount4 = {2'h0, v[0]} + {2'h0, v[1]}
				+ {2'h0, v[2]} + {2'h0, v[3]};
		end
	endfunction

	function [7:0] limit_deg;
		input [1:0] sel;
		begin
			case (sel)
				2'h1: limit_deg = `LIM_A_C;
				2'h2: limit_deg = `LIM_B_C;
				2'h3: limit_deg = `LIM_C_C;
				default: limit_deg = 8'hff;
			endcase
		end
	endfunction

// ---------------------------------------------------------------
// pin synchronisation
// ---------------------------------------------------------------
	localparam SW = 2 + 4 * `STR_N + 2 + `TEMP_W;

	wire [SW-1:0]  sync_q;
	wire           en;
	wire           mixed;
	wire [3:0]     s_low;
	wire [3:0]     s_high;
	wire [3:0]     s_open;
	wire [3:0]     s_short;
	wire           s_supply;
	wire           s_ocp;
	wire [10:0]    s_temp;

	// the temperature word may tear for one sample on a code change;
	// a single-cycle glitch disturbs derating for one cycle, but can also trip the 150 degree shutdown and record a fault
	pin_sync #(
		.W (SW)
	) u_sync (
		.clk (REF_CLK),
		.rst (RST),
		.d   ({EN_PIN, MIXED_DIM, HEAD_LOW, HEAD_HIGH, STR_OPEN,
			STR_SHORT, SUPPLY_LOW, OVER_CURRENT, TEMP_CODE}),
		.q   (sync_q)
	);

	assign {en, mixed, s_low, s_high, s_open, s_short,
		s_supply, s_ocp, s_temp} = sync_q;

// ---------------------------------------------------------------
// configuration registers
// ---------------------------------------------------------------
	reg  [7:0] cfg0_ff;
	reg  [7:0] cfg1_ff;
	wire [4:0] code;
	wire [1:0] supply_sel;
	wire [1:0] heat_sel;
	wire       adaptive;
	wire       auto_boost;
	wire       sw_start;

	assign code       = cfg0_ff[`F_CODE_HI:`F_CODE_LO];
	assign supply_sel = cfg1_ff[`F_SUPPLY_HI:`F_SUPPLY_LO];
	assign heat_sel   = cfg1_ff[`F_HEAT_HI:`F_HEAT_LO];
	assign adaptive   = cfg1_ff[`F_ADAPT];
	assign auto_boost = cfg1_ff[`F_AUTO_BOOST];
	assign sw_start   = cfg1_ff[`F_SW_START];

	always @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cfg0_ff <= `CFG0_RST;
			cfg1_ff <= `CFG1_RST;
		end else if (WR) begin
			if (ADDR == `ADR_CFG0)
				cfg0_ff <= WDATA;
			if (ADDR == `ADR_CFG1)
				cfg1_ff <= WDATA;
		end
	end

// ---------------------------------------------------------------
// fault detection and record
// ---------------------------------------------------------------
	reg        open_ff;
	reg        short_ff;
	reg        uv_ff;
	reg        oc_ff;
	reg        tsd_ff;
	reg  [3:0] bad_ff;
	reg        tsd_act_ff;
	reg        led_on_ff;
	wire       rd_fault;
	wire       clr;
	wire       det_en;
	wire [3:0] new_open;
	wire [3:0] new_short;
	wire       uv_now;
	wire       halt;
	wire [7:0] temp_deg;

	assign temp_deg = s_temp[`TEMP_W-1:`TEMP_FRAC];
	assign rd_fault = RD & (ADDR == `ADR_FAULT);
	assign clr = rd_fault | ~en;

	assign det_en    = en & led_on_ff & mixed;
	assign new_open  = s_open & {4{det_en}};
	assign new_short = s_short & {4{det_en}};

	assign uv_now = en & (supply_sel != 2'h0) & s_supply;

	assign halt = uv_now | oc_ff | tsd_act_ff;

	always @(posedge REF_CLK or posedge RST) begin
		if (RST)
			tsd_act_ff <= 1'b0;
		else if (temp_deg >= `TSD_ON_C)
			tsd_act_ff <= 1'b1;
		else if (temp_deg < `TSD_OFF_C)
			tsd_act_ff <= 1'b0;
	end

	// a fresh event wins over a clear in the same cycle
	// record cause
	always @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			open_ff  <= 1'b0;
			short_ff <= 1'b0;
			uv_ff    <= 1'b0;
			oc_ff    <= 1'b0;
			tsd_ff   <= 1'b0;
			bad_ff   <= 4'h0;
		end else begin
			open_ff  <= (open_ff & ~clr) | (|new_open);
			short_ff <= (short_ff & ~clr) | (|new_short);
			uv_ff    <= (uv_ff & ~clr) | uv_now;
			oc_ff    <= (oc_ff & ~clr) | (en & s_ocp);
			tsd_ff   <= (tsd_ff & ~clr) | (en & tsd_act_ff);
			bad_ff   <= (bad_ff & {4{~clr}}) | new_open | new_short;
		end
	end

// ---------------------------------------------------------------
// boost and led enables, adaptive loop
// ---------------------------------------------------------------
	wire [3:0] in_loop;
	wire       raise;
	wire       lower;

	assign in_loop = ~bad_ff;
	assign raise = |(s_low & in_loop);
	assign lower = (&(s_high | bad_ff)) & (|in_loop);

	always @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			BOOST_ON  <= 1'b0;
			LED_ON    <= 1'b0;
			led_on_ff <= 1'b0;
		end else begin
			BOOST_ON  <= en & (auto_boost | sw_start) & ~halt;
			LED_ON    <= en & ~halt;
			led_on_ff <= en & ~halt;
		end
	end

	boost_setpoint #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_setpoint (
		.clk         (REF_CLK),
		.rst         (RST),
		.run         (BOOST_ON),
		.adaptive    (adaptive),
		.manual_code (code),
		.raise       (raise),
		.lower       (lower),
		.setpoint    (BOOST_SET)
	);

// ---------------------------------------------------------------
// analog selects and protection outputs
// ---------------------------------------------------------------
	always @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			OVP_SET        <= `OVP_MARGIN;
			MARGIN_SEL     <= 3'h0;
			MISMATCH_SEL   <= 1'b0;
			SUPPLY_LOW_SEL <= 2'h0;
			LOOP_MASK      <= 4'hf;
			FAULT_O        <= 1'b0;
			FAULT_OE       <= 1'b0;
		end else begin
			OVP_SET        <= {1'b0, BOOST_SET} + `OVP_MARGIN;
			MARGIN_SEL     <= cfg0_ff[`F_MARGIN_HI:`F_MARGIN_LO];
			MISMATCH_SEL   <= cfg1_ff[`F_MISMATCH];
			SUPPLY_LOW_SEL <= supply_sel;
			LOOP_MASK      <= in_loop;
			FAULT_O        <= 1'b0;
			FAULT_OE       <= open_ff | short_ff | uv_ff | oc_ff | tsd_ff;
		end
	end

// ---------------------------------------------------------------
// thermal derating
// ---------------------------------------------------------------
	reg  [8:0] nxt_duty;
	wire [7:0] lim;
	wire [7:0] excess;
	wire [8:0] cut;

	assign lim    = limit_deg(heat_sel);
	assign excess = temp_deg - lim;
	assign cut    = {1'b0, excess} * `DERATE_PCT;

	always @* begin
		nxt_duty = `FULL_DUTY;
		if (en & (heat_sel != 2'h0) & (temp_deg > lim)) begin
			if (cut >= `FULL_DUTY)
				nxt_duty = 9'h000;
			else
				nxt_duty = `FULL_DUTY - cut;
		end
	end

	always @(posedge REF_CLK or posedge RST) begin
		if (RST)
			DUTY_PCT <= `DUTY_RST;
		else
			DUTY_PCT <= nxt_duty[6:0];
	end

// ---------------------------------------------------------------
// register read port
// ---------------------------------------------------------------
	reg  [2:0] lo_snap_ff;
	reg  [7:0] nxt_rdata;
	wire [7:0] fault_word;

	assign fault_word = {tsd_ff, oc_ff, uv_ff, popcount4(bad_ff),
		short_ff, open_ff};

	always @* begin
		nxt_rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				`ADR_CFG0:     nxt_rdata = cfg0_ff;
				`ADR_CFG1:     nxt_rdata = cfg1_ff;
				`ADR_FAULT:    nxt_rdata = fault_word;
				`ADR_TEMP_HI:  nxt_rdata = temp_deg;
				`ADR_TEMP_LO:  nxt_rdata = {5'h00, lo_snap_ff};
				`ADR_SETPOINT: nxt_rdata = BOOST_SET;
				`ADR_DUTY:     nxt_rdata = {1'b0, DUTY_PCT};
				default:       nxt_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			lo_snap_ff <= 3'h0;
			RDATA      <= 8'h00;
		end else begin
			if (RD & (ADDR == `ADR_TEMP_HI))
				lo_snap_ff <= s_temp[`TEMP_FRAC-1:0];
			RDATA <= nxt_rdata;
		end
	end
endmodule // backlight_supervisor

// ---- bl_regs.vh ----
// register map, field positions, reset values and timing constants
`ifndef BL_REGS_VH
`define BL_REGS_VH

// register indices
`define ADR_CFG0       8'h00
`define ADR_CFG1       8'h01
`define ADR_FAULT      8'h02
`define ADR_TEMP_HI    8'h03
`define ADR_TEMP_LO    8'h04
`define ADR_SETPOINT   8'h05
`define ADR_DUTY       8'h06

// reset values
`define CFG0_RST       8'h00
`define CFG1_RST       8'h40

// cfg0 fields
`define F_CODE_LO      0
`define F_CODE_HI      4
`define F_MARGIN_LO    5
`define F_MARGIN_HI    7

// cfg1 fields
`define F_ADAPT        0
`define F_MISMATCH     1
`define F_SUPPLY_LO    2
`define F_SUPPLY_HI    3
`define F_HEAT_LO      4
`define F_HEAT_HI      5
`define F_AUTO_BOOST   6
`define F_SW_START     7

// setpoint arithmetic, one step is 125 mV above the 10 V floor
`define STEP_MV        125
`define STEPS_PER_VOLT 8'h08
`define CODE_SAT       5'h1e
`define SET_MAX        8'hf0
`define OVP_MARGIN     9'h010

// temperature
`define TEMP_W         11
`define TEMP_FRAC      3
`define TSD_ON_C       8'h96
`define TSD_OFF_C      8'h82
`define LIM_A_C        8'h6e
`define LIM_B_C        8'h78
`define LIM_C_C        8'h82
`define FULL_DUTY      9'h064
`define DUTY_RST       7'h64
`define DERATE_PCT     9'h002

// adaptive loop update period
`define CLK_PERIOD_NS  100
`define STEP_TIME_NS   10000
`define STEP_CYCLES    (`STEP_TIME_NS / `CLK_PERIOD_NS)

`define STR_N          4

`endif

// ---- pin_sync.v ----
// two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module pin_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_ff;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= {W{1'b0}};
			q       <= {W{1'b0}};
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule // pin_sync

// ---- boost_setpoint.v ----
// boost voltage setpoint: manual code or adaptive 125 mV stepping
`timescale 1ns/100ps
`include "bl_regs.vh"
module boost_setpoint #(
	parameter STEP_CYCLES = `STEP_CYCLES
) (
	input  wire       clk,
	input  wire       rst,
	input  wire       run,
	input  wire       adaptive,
	input  wire [4:0] manual_code,
	input  wire       raise,
	input  wire       lower,
	output reg  [7:0] setpoint
);
	reg  [15:0] tick_ff;
	reg         run_ff;
	wire        tick;
	wire [7:0]  man_steps;

	// codes 30 and 31 both give 40 V
	function [7:0] code_steps;
		input [4:0] c;
		begin
			if (c >= `CODE_SAT)
				code_steps = `SET_MAX;
			else
				code_steps = {3'h0, c} * `STEPS_PER_VOLT;
		end
	endfunction

	assign man_steps = code_steps(manual_code);
	assign tick = (tick_ff == STEP_CYCLES - 1);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_ff  <= 16'h0000;
			run_ff   <= 1'b0;
			setpoint <= 8'h00;
		end else begin
			run_ff  <= run;
			tick_ff <= (tick | ~run) ? 16'h0000 : tick_ff + 16'h0001;
			if (~run | ~run_ff | ~adaptive) begin
				setpoint <= man_steps;
			end else if (tick & raise & (setpoint < `SET_MAX)) begin
				setpoint <= setpoint + 8'h01;
			end else if (tick & lower & (setpoint != 8'h00)) begin
				setpoint <= setpoint - 8'h01;
			end
		end
	end
endmodule // boost_setpoint

// ---- bl_checker.sv ----
// concurrent checks on the backlight supervisor ports
`timescale 1ns/100ps
module bl_checker #(
	parameter STEP_CYCLES = 4
) (
	input wire        REF_CLK,
	input wire        RST,
	input wire        RD,
	input wire [7:0]  ADDR,
	input wire        EN_PIN,
	input wire        MIXED_DIM,
	input wire [3:0]  STR_OPEN,
	input wire        SUPPLY_LOW,
	input wire        OVER_CURRENT,
	input wire [10:0] TEMP_CODE,
	input wire        BOOST_ON,
	input wire        LED_ON,
	input wire [7:0]  BOOST_SET,
	input wire [8:0]  OVP_SET,
	input wire [1:0]  SUPPLY_LOW_SEL,
	input wire [3:0]  LOOP_MASK,
	input wire [6:0]  DUTY_PCT,
	input wire        FAULT_O,
	input wire        FAULT_OE
);
	// ---------------------------------------------------------------
	// helper and assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// cycles since last clear cause; the pin may only drop shortly after one
	logic [2:0] age_ff;
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) age_ff <= 3'h7;
		else if ((RD && ADDR == 8'h02) || !EN_PIN) age_ff <= 3'h0;
		else if (age_ff != 3'h7) age_ff <= age_ff + 3'h1;
	end
	AST_OVP_TRACK: assert property (OVP_SET == {1'b0, $past(BOOST_SET)} + 9'h010)
		else $error("over-voltage limit not tracking setpoint");
	AST_SET_MAX: assert property (BOOST_SET <= 8'hf0)
		else $error("setpoint above 40 V");
	AST_PIN_LOW: assert property (FAULT_O == 1'b0)
		else $error("fault pin driven high");
	AST_FAULT_HOLD: assert property ($fell(FAULT_OE) |-> age_ff <= 3'h4)
		else $error("fault pin released without clear");
	AST_OC_STOP: assert property ((OVER_CURRENT && EN_PIN) [*7] |-> !BOOST_ON && !LED_ON && FAULT_OE)
		else $error("over-current did not shut down");
	AST_UV_STOP: assert property ((SUPPLY_LOW && SUPPLY_LOW_SEL != 2'h0) [*6] |-> !BOOST_ON)
		else $error("supply low did not stop boost");
	AST_TSD_STOP: assert property ((TEMP_CODE[10:3] >= 8'h96) [*6] |-> !BOOST_ON && !LED_ON)
		else $error("overheat did not shut down");
	AST_NO_DERATE: assert property ((TEMP_CODE[10:3] < 8'h6e) [*4] |-> DUTY_PCT == 7'h64)
		else $error("duty reduced below limit");
	AST_MASK_OUT: assert property ((STR_OPEN[0] && EN_PIN && MIXED_DIM && LED_ON) [*6] |-> !LOOP_MASK[0])
		else $error("faulty string still in loop");
	AST_EN_CLEAR: assert property ((!EN_PIN) [*6] |-> !FAULT_OE && !BOOST_ON)
		else $error("enable low left fault or boost");
	cover property (FAULT_OE ##1 !FAULT_OE);
	cover property (EN_PIN && !BOOST_ON);
	cover property (BOOST_ON && $changed(BOOST_SET));
endmodule // bl_checker

bind backlight_supervisor bl_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
	.REF_CLK(REF_CLK), .RST(RST), .RD(RD), .ADDR(ADDR), .EN_PIN(EN_PIN),
	.MIXED_DIM(MIXED_DIM), .STR_OPEN(STR_OPEN), .SUPPLY_LOW(SUPPLY_LOW),
	.OVER_CURRENT(OVER_CURRENT), .TEMP_CODE(TEMP_CODE), .BOOST_ON(BOOST_ON),
	.LED_ON(LED_ON), .BOOST_SET(BOOST_SET), .OVP_SET(OVP_SET),
	.SUPPLY_LOW_SEL(SUPPLY_LOW_SEL), .LOOP_MASK(LOOP_MASK), .DUTY_PCT(DUTY_PCT),
	.FAULT_O(FAULT_O), .FAULT_OE(FAULT_OE));

// ---- string_model.sv ----
// boost stage and led strings answering with headroom comparator levels
`timescale 1ns/100ps
module string_model (
	input  wire       BOOST_ON,
	input  wire [7:0] BOOST_SET,
	input  wire [2:0] MARGIN_SEL,
	output reg  [3:0] HEAD_LOW,
	output reg  [3:0] HEAD_HIGH
);
	// forward drop per string in 125 mV steps over 10 V; string 0 is the worst
	localparam [31:0] VF = {8'h38, 8'h38, 8'h38, 8'h40};
	integer i;
	integer hr;
	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			hr = BOOST_ON ? int'(BOOST_SET) - int'(VF[8*i +: 8]) : -99;
			HEAD_LOW[i] = hr < int'(MARGIN_SEL) + 2;
			HEAD_HIGH[i] = hr > int'(MARGIN_SEL) + 3;
		end
	end
endmodule // string_model

// ---- tb.sv ----
// self-checking bench for the backlight supervisor
`timescale 1ns/100ps
`include "bl_regs.vh"
module tb;
	logic        REF_CLK = 0, RST = 1, WR = 0, RD = 0, EN_PIN = 0, MIXED_DIM = 0;
	logic        SUPPLY_LOW = 0, OVER_CURRENT = 0, rd_d = 0;
	logic [7:0]  ADDR = 0, WDATA = 0, t;
	logic [3:0]  STR_OPEN = 0, STR_SHORT = 0;
	logic [10:0] TEMP_CODE = 0;
	wire  [7:0]  RDATA, BOOST_SET;
	wire  [3:0]  HEAD_LOW, HEAD_HIGH, LOOP_MASK;
	wire         BOOST_ON, LED_ON, MISMATCH_SEL, FAULT_O, FAULT_OE;
	wire  [8:0]  OVP_SET;
	wire  [2:0]  MARGIN_SEL;
	wire  [1:0]  SUPPLY_LOW_SEL;
	wire  [6:0]  DUTY_PCT;
	logic [7:0]  exp_q[$];
	logic [7:0]  tt[3] = '{8'h96, 8'h87, 8'h81};
	logic [15:0] lf = 16'h0c1f;
	logic [4:0]  c;
	int          i, fail_count = 0, samples_checked = 0, cyc = 0;
	backlight_supervisor #(.STEP_CYCLES(4)) DUT (
		.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .EN_PIN(EN_PIN), .MIXED_DIM(MIXED_DIM), .HEAD_LOW(HEAD_LOW),
		.HEAD_HIGH(HEAD_HIGH), .STR_OPEN(STR_OPEN), .STR_SHORT(STR_SHORT),
		.SUPPLY_LOW(SUPPLY_LOW), .OVER_CURRENT(OVER_CURRENT), .TEMP_CODE(TEMP_CODE),
		.BOOST_ON(BOOST_ON), .LED_ON(LED_ON), .BOOST_SET(BOOST_SET), .OVP_SET(OVP_SET),
		.MARGIN_SEL(MARGIN_SEL), .MISMATCH_SEL(MISMATCH_SEL),
		.SUPPLY_LOW_SEL(SUPPLY_LOW_SEL), .LOOP_MASK(LOOP_MASK), .DUTY_PCT(DUTY_PCT),
		.FAULT_O(FAULT_O), .FAULT_OE(FAULT_OE));
	string_model u_str (
		.BOOST_ON(BOOST_ON), .BOOST_SET(BOOST_SET), .MARGIN_SEL(MARGIN_SEL),
		.HEAD_LOW(HEAD_LOW), .HEAD_HIGH(HEAD_HIGH));
	initial forever #50 REF_CLK = ~REF_CLK;
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc_wait(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1;
		@(posedge REF_CLK);
		WR <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge REF_CLK);
		ADDR <= a;
		RD <= 1;
		exp_q.push_back(e);
		@(posedge REF_CLK);
		RD <= 0;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge REF_CLK) begin
		if (rd_d) chk("rdata", RDATA, exp_q.pop_front());
		rd_d <= RD;
	end
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			complete_run;
		end
	end
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		cyc_wait(3);
		RST <= 0;
		rd(`ADR_CFG0, 8'h00);
		rd(`ADR_CFG1, 8'h40);
		rd(8'h07, 8'h00);
		wr(`ADR_CFG1, 8'h42);
		cyc_wait(1);
		@(negedge REF_CLK);
		chk("mismatch", MISMATCH_SEL, 8'h01);
		for (i = 0; i < 8; i++) begin
			lf = nx(lf);
			c = (i < 2) ? 5'h1e + i[4:0] : lf[4:0];
			wr(`ADR_CFG0, {lf[7:5], c});
			rd(`ADR_SETPOINT, (c > 5'h1d ? 8'h1e : {3'h0, c}) * 8'h08);
			@(negedge REF_CLK);
			chk("margin", MARGIN_SEL, lf[7:5]);
		end
		wr(`ADR_CFG0, 8'h05);
		wr(`ADR_CFG1, 8'h41);
		EN_PIN <= 1;
		cyc_wait(5);
		@(negedge REF_CLK);
		chk("start", BOOST_SET, 8'h28);
		cyc_wait(300);
		rd(`ADR_SETPOINT, 8'h42);
		STR_SHORT <= 4'h6;
		cyc_wait(8);
		rd(`ADR_FAULT, 8'h00);
		MIXED_DIM <= 1;
		cyc_wait(8);
		STR_SHORT <= 4'h0;
		cyc_wait(4);
		@(negedge REF_CLK);
		chk("pin", FAULT_OE, 8'h01);
		rd(`ADR_FAULT, 8'h0a);
		STR_OPEN <= 4'h1;
		cyc_wait(100);
		@(negedge REF_CLK);
		chk("mask", LOOP_MASK, 8'h0e);
		rd(`ADR_SETPOINT, 8'h3b);
		STR_OPEN <= 4'h0;
		cyc_wait(4);
		rd(`ADR_FAULT, 8'h05);
		rd(`ADR_FAULT, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(`ADR_CFG1, {4'h4, i[1:0], 2'h0});
			SUPPLY_LOW <= 1;
			cyc_wait(8);
			@(negedge REF_CLK);
			chk("uv_run", BOOST_ON, i == 0);
			chk("uv_sel", SUPPLY_LOW_SEL, i[1:0]);
			cyc_wait(1);
			SUPPLY_LOW <= 0;
			cyc_wait(8);
			@(negedge REF_CLK);
			chk("uv_back", BOOST_ON, 8'h01);
			rd(`ADR_FAULT, (i == 0) ? 8'h00 : 8'h20);
		end
		OVER_CURRENT <= 1;
		cyc_wait(7);
		OVER_CURRENT <= 0;
		cyc_wait(6);
		@(negedge REF_CLK);
		chk("oc_off", BOOST_ON, 8'h00);
		chk("oc_pin", FAULT_OE, 8'h01);
		cyc_wait(1);
		EN_PIN <= 0;
		cyc_wait(6);
		EN_PIN <= 1;
		cyc_wait(8);
		@(negedge REF_CLK);
		chk("en_clr", FAULT_OE, 8'h00);
		chk("oc_back", BOOST_ON, 8'h01);
		for (i = 1; i < 4; i++) begin
			wr(`ADR_CFG1, {2'h1, i[1:0], 4'h0});
			t = 8'h69 + 8'h0a * i[7:0];
			TEMP_CODE <= {t, 3'h5};
			cyc_wait(6);
			rd(`ADR_DUTY, 8'h5a);
			rd(`ADR_FAULT, 8'h00);
		end
		rd(`ADR_TEMP_HI, t);
		rd(`ADR_TEMP_LO, 8'h05);
		wr(`ADR_CFG1, 8'h40);
		for (i = 0; i < 3; i++) begin
			TEMP_CODE <= {tt[i], 3'h0};
			cyc_wait(8);
			@(negedge REF_CLK);
			chk("tsd_run", BOOST_ON, i == 2);
			cyc_wait(1);
		end
		rd(`ADR_FAULT, 8'h80);
		cyc_wait(3);
		complete_run;
	end
endmodule // tb
